// >>> hw/isac_regs.svh
`ifndef ISAC_REGS_SVH
`define ISAC_REGS_SVH
`define ISAC_SECTIONS        18
`define ISAC_LATENCY         14
`define ISAC_CAL_CYCLES      10000
`define ISAC_CODE_BITS       12
`define ISAC_FULL_CODE       12'hfff
`define ISAC_PH_REF_ZERO     5'h00
`define ISAC_PH_AUTO_ZERO    5'h01
`define ISAC_PH_AUTO_CAL     5'h02
`define ISAC_PH_SAMPLE       5'h03
`define ISAC_PH_SAR_FIRST    5'h04
`define ISAC_PH_SAR_LAST     5'h10
`define ISAC_PH_TRANSFER     5'h11
`define ISAC_FIFO_DEPTH      4
`endif

// >>> hw/isac_pkg.sv
package isac_pkg;
  typedef struct packed {
    logic        overrange_flag_bit;
    logic [11:0] sample_code_bits;
  } isac_word_type;
  typedef enum logic [3:0] {
    ISAC_REF_ZERO = 4'b0001,
    ISAC_AUTO_ZERO = 4'b0010,
    ISAC_AUTO_CAL = 4'b0100,
    ISAC_CONVERT = 4'b1000
  } isac_step_type;
endpackage

// >>> hw/isac_fifo.sv
module isac_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side.
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side.
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;
  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// >>> hw/isac_core.sv
`include "isac_regs.svh"
// Notes on behaviour
// - Section cycle: refzero, autozero, cal, sample, SAR, transfer.
// - Eighteen-phase sequence from the single clock.
// - Neighbour sections offset one clock; one samples.
// - Whole pattern repeats every eighteen clocks.
// - Output word appears fourteen clocks after sampling.
// - Self-calibration starts at power-up, 10000 clocks minimum.
// - Calibration steps on rising edges; clock must run.
// - Output word updates each rising edge the buffer holds a word, else holds.
// - Enable low drives outputs; high releases all.
// - Twelve bits straight binary, zero to full scale.
// - Overrange set when input exceeds full scale.
// - Overrange forces all twelve code bits high.
module isac_core
  import isac_pkg::*;
#(
  parameter int SECTIONS  = `ISAC_SECTIONS,
  parameter int LATENCY   = `ISAC_LATENCY,
  parameter int CAL_COUNT = `ISAC_CAL_CYCLES
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rstn,
  // Quantiser results: code of the sampling section and over-full-scale flag.
  input  wire logic [11:0] quant_code,
  input  wire logic        quant_over,
  // Output enable pin, active low.
  input  wire logic        out_en_n,
  // Data pins: value and per-bit output enable (low while driving).
  output logic [11:0]      sample_code_bits,
  output logic [11:0]      sample_code_bits_oe_n,
  output logic             out_of_range_output,
  output logic             out_of_range_output_oe_n,
  // Status.
  output logic             cal_done,
  output logic [4:0]       sampling_section
);
  // The step decode and the output select are built for the eighteen-section wheel only.
  initial begin
    if (SECTIONS != 18) begin
      $error("SECTIONS must be 18");
    end
    if (LATENCY < 2 || LATENCY > SECTIONS) begin
      $error("LATENCY must lie between 2 and SECTIONS");
    end
    if (CAL_COUNT < 1) begin
      $error("CAL_COUNT must be at least 1");
    end
    if (`ISAC_PH_TRANSFER != SECTIONS - 1 || `ISAC_PH_SAR_LAST - `ISAC_PH_SAR_FIRST != 12) begin
      $error("Step numbering does not fit an eighteen-step section cycle");
    end
    if (`ISAC_FIFO_DEPTH < 2) begin
      $error("Output buffer must hold at least two words");
    end
  end

  localparam int SW = 5;
  localparam int CW = $clog2(CAL_COUNT + 1);

  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // The enable pin comes from the capture side, so it is synchronised.
  // The cost is that the drivers follow the pin three clocks late.
  logic en_meta;
  logic en_sync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_meta   <= 1'b1;
      en_sync_n <= 1'b1;
    end else begin
      en_meta   <= out_en_n;
      en_sync_n <= en_meta;
    end
  end

  // Master phase: the section that samples on this clock.
  // It wraps at SECTIONS, which sets the period of the whole pattern.
  logic [SW-1:0] phase;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= '0;
    end else if (phase == SW'(SECTIONS - 1)) begin
      phase <= '0;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  // Each section's step is the master phase shifted by its index.
  logic [SW-1:0]  sec_step [SECTIONS];
  isac_step_type  sec_state [SECTIONS];
  isac_word_type  sec_result [SECTIONS];
  logic           sec_loaded [SECTIONS];
  genvar g;
  generate
    for (g = 0; g < SECTIONS; g++) begin : gen_sec
      always_comb begin
        if (phase >= SW'(g)) begin
          sec_step[g] = SW'(`ISAC_PH_SAMPLE) + phase - SW'(g);
        end else begin
          sec_step[g] = SW'(`ISAC_PH_SAMPLE) + phase + SW'(SECTIONS) - SW'(g);
        end
        if (sec_step[g] >= SW'(SECTIONS)) begin
          sec_step[g] = sec_step[g] - SW'(SECTIONS);
        end
      end
      // Sample, SAR and transfer steps share the converting state.
      always_comb begin
        case (sec_step[g])
          `ISAC_PH_REF_ZERO:  sec_state[g] = ISAC_REF_ZERO;
          `ISAC_PH_AUTO_ZERO: sec_state[g] = ISAC_AUTO_ZERO;
          `ISAC_PH_AUTO_CAL:  sec_state[g] = ISAC_AUTO_CAL;
          default:            sec_state[g] = ISAC_CONVERT;
        endcase
      end
      // A section captures the quantiser on its sample step and holds it through SAR and transfer.
      // Zero and calibration steps never capture, whatever the step count says.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sec_result[g] <= '0;
        end else if (sec_state[g] == ISAC_CONVERT && sec_step[g] == `ISAC_PH_SAMPLE) begin
          sec_result[g].overrange_flag_bit <= quant_over;
          sec_result[g].sample_code_bits   <= quant_over ? `ISAC_FULL_CODE : quant_code;
        end
      end
      // A section that has not sampled since reset has nothing to hand over.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sec_loaded[g] <= 1'b0;
        end else if (sec_step[g] == `ISAC_PH_SAMPLE) begin
          sec_loaded[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // The word leaves on the cycle the sampling section is LATENCY steps past its sample.
  // One step less is counted here: the buffer adds one clock ahead of the output register.
  logic [SW-1:0] out_sec;
  always_comb begin
    if (phase >= SW'(LATENCY - 1)) begin
      out_sec = phase - SW'(LATENCY - 1);
    end else begin
      out_sec = phase + SW'(SECTIONS) - SW'(LATENCY - 1);
    end
  end

  // Four-word buffer in the path; the drain always pops, so it never backs up.
  isac_word_type fifo_out;
  logic          fifo_valid;
  logic          fill_valid;
  // Only sections that have sampled since reset feed the buffer.
  assign fill_valid = sec_loaded[out_sec];
  isac_fifo #(
    .WIDTH ($bits(isac_word_type)),
    .DEPTH (`ISAC_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (sec_result[out_sec]),
    .in_valid  (fill_valid),
    .in_ready  (),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (1'b1)
  );

  // Output register updates on each rising edge that the buffer holds a word, and holds otherwise.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_code_bits    <= '0;
      out_of_range_output <= 1'b0;
    end else if (fifo_valid) begin
      sample_code_bits    <= fifo_out.sample_code_bits;
      out_of_range_output <= fifo_out.overrange_flag_bit;
    end
  end

  // Drivers release while enable is high; the pipeline above ignores the enable.
  // A clocked enable path keeps every pin control a flip-flop output.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_code_bits_oe_n    <= '1;
      out_of_range_output_oe_n <= 1'b1;
    end else begin
      sample_code_bits_oe_n    <= {12{en_sync_n}};
      out_of_range_output_oe_n <= en_sync_n;
    end
  end

  // Calibration runs from reset release, one step per rising edge.
  // The count does not restart by itself; only a reset repeats calibration.
  logic [CW-1:0] cal_count;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_count <= '0;
      cal_done  <= 1'b0;
    end else if (cal_count != CW'(CAL_COUNT)) begin
      cal_count <= cal_count + 1'b1;
      cal_done  <= (cal_count == CW'(CAL_COUNT - 1));
    end
  end

  // Registered copy of the master phase, so the status port leaves a flip-flop.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sampling_section <= '0;
    else        sampling_section <= (phase == SW'(SECTIONS - 1)) ? '0 : phase + 1'b1;
  end
endmodule

// >>> bench/isac_core_sva.sv
module isac_core_chk
  import isac_pkg::*;
#(
  parameter int CAL_COUNT = 20
) (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rstn,
  // Inputs of the core.
  input wire logic [11:0] quant_code,
  input wire logic        quant_over,
  input wire logic        out_en_n,
  // Outputs of the core.
  input wire logic [11:0] sample_code_bits,
  input wire logic [11:0] sample_code_bits_oe_n,
  input wire logic        out_of_range_output,
  input wire logic        out_of_range_output_oe_n,
  input wire logic        cal_done,
  input wire logic [4:0]  sampling_section
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // History checks wait until the pipe holds only samples taken after reset.
  int age;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) age <= 0;
    else if (age < 100000) age <= age + 1;
  end
  code_latency_a: assert property (age > 20 |->
    sample_code_bits == ($past(quant_over, 15) ? 12'hfff : $past(quant_code, 15))) else $error("word latency");
  over_latency_a: assert property (age > 20 |->
    out_of_range_output == $past(quant_over, 15)) else $error("overrange latency");
  section_step_a: assert property (age > 3 && sampling_section != 5'h11 |=>
    sampling_section == $past(sampling_section) + 5'h01) else $error("section step");
  section_wrap_a: assert property (sampling_section == 5'h11 |=>
    sampling_section == 5'h00) else $error("section wrap");
  oe_track_a: assert property (age > 6 ##0 $stable(out_en_n) [*4] |->
    out_of_range_output_oe_n == out_en_n) else $error("enable tracking");
  oe_equal_a: assert property (sample_code_bits_oe_n == {12{out_of_range_output_oe_n}})
    else $error("enables differ");
  cal_early_a: assert property (cal_done |-> age >= CAL_COUNT) else $error("calibration early");
  cal_late_a: assert property (age >= CAL_COUNT + 4 |-> cal_done) else $error("calibration late");
  cover property (out_of_range_output);
  cover property ($rose(cal_done));
  cover property (out_of_range_output_oe_n && age > 20);
endmodule

// >>> bench/isac_capture.sv
module isac_capture
  import isac_pkg::*;
(
  // Pins seen from the capture side.
  input  wire logic [11:0] code,
  input  wire logic [11:0] code_oe_n,
  input  wire logic        over,
  input  wire logic        over_oe_n,
  // Resolved wire levels.
  output isac_word_type    pins
);
  timeunit 1ns;
  timeprecision 1ps;
  isac_word_type held = '0;
  // Nothing pulls the pins, so released ones show the inverse of the last driven level.
  always_comb begin
    for (int i = 0; i < 12; i++) pins.sample_code_bits[i] = code_oe_n[i] ? ~held.sample_code_bits[i] : code[i];
    pins.overrange_flag_bit = over_oe_n ? ~held.overrange_flag_bit : over;
  end
  always @(code or over or over_oe_n) if (!over_oe_n) held = {over, code};
endmodule

// >>> bench/interleaved_sar_adc_output_timing_tb.sv
module interleaved_sar_adc_output_timing_tb
  import isac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL = 20;
  typedef struct packed { logic [11:0] code; logic over; isac_word_type exp; } isac_row_type;
  localparam isac_row_type ROWS [7] = '{'{12'h000, 1'b0, 13'h0000}, '{12'hfff, 1'b0, 13'h0fff},
    '{12'h800, 1'b0, 13'h0800}, '{12'h001, 1'b0, 13'h0001}, '{12'hffe, 1'b0, 13'h0ffe},
    '{12'h123, 1'b1, 13'h1fff}, '{12'h555, 1'b0, 13'h0555}};
  logic clk = 1'b0, rstn = 1'b0, quant_over = 1'b0, out_en_n = 1'b0;
  logic [11:0] quant_code = 12'h000, code, code_oe_n;
  logic over, over_oe_n, cal_done;
  logic [4:0] section, s;
  isac_word_type pins;
  int n_mismatch = 0, n_tests = 0, t = 0;
  always #5 clk = ~clk;
  isac_core #(.CAL_COUNT(CAL)) u_dut (.clk(clk), .rstn(rstn), .quant_code(quant_code), .quant_over(quant_over),
    .out_en_n(out_en_n), .sample_code_bits(code), .sample_code_bits_oe_n(code_oe_n), .out_of_range_output(over),
    .out_of_range_output_oe_n(over_oe_n), .cal_done(cal_done), .sampling_section(section));
  isac_capture u_far (.code(code), .code_oe_n(code_oe_n), .over(over), .over_oe_n(over_oe_n), .pins(pins));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    step(8);
    check({over_oe_n, code_oe_n, cal_done}, 32'h3ffe);
    rstn = 1'b1;
    while (cal_done !== 1'b1 && t < 200) begin
      step(1);
      t++;
    end
    check(32'(t >= CAL && t <= CAL + 4), 32'h1);
    s = section;
    step(18);
    check(section, s);
    step(1);
    check(section, (s == 5'h11) ? 5'h00 : s + 5'h01);
    for (int j = 0; j < 22; j++) begin
      if (j < 7) {quant_code, quant_over} = {ROWS[j].code, ROWS[j].over};
      if (j >= 15) check(pins, ROWS[j - 15].exp);
      step(1);
    end
    out_en_n = 1'b1;
    s = section;
    step(4);
    check({over_oe_n, code_oe_n}, 32'h1fff);
    check(section, 5'((s + 4) % 18));
    out_en_n = 1'b0;
    step(4);
    check(pins, 13'h0555);
    rstn = 1'b0;
    #1;
    check({over_oe_n, code_oe_n, cal_done}, 32'h3ffe);
    check(section, 5'h00);
    step(2);
    rstn = 1'b1;
    step(2);
    check(section, 5'h00);
    step(1);
    check(section, 5'h01);
    check({over_oe_n, code_oe_n, cal_done}, 32'h3ffe);
    tally_and_finish();
  end
endmodule
bind isac_core isac_core_chk #(.CAL_COUNT(CAL_COUNT)) u_chk (.clk(clk), .rstn(rstn), .quant_code(quant_code),
  .quant_over(quant_over), .out_en_n(out_en_n), .sample_code_bits(sample_code_bits),
  .sample_code_bits_oe_n(sample_code_bits_oe_n), .out_of_range_output(out_of_range_output),
  .out_of_range_output_oe_n(out_of_range_output_oe_n), .cal_done(cal_done), .sampling_section(sampling_section));
